/* File: rtl/shc_pkg.sv */
`default_nettype none
package shc_pkg;
	// ****************************************
	// serial frame
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam int CMD_BITS = 8;
	localparam logic [4:0] CNT_CMD_LAST = 5'h07;
	localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;
	localparam logic [4:0] CNT_DONE = 5'h10;

	// ****************************************
	// device command registers (7-bit address)
	// ****************************************
	localparam logic [6:0] DREG_CTRL = 7'h00;
	localparam logic [6:0] DREG_IMASK = 7'h01;
	localparam logic [6:0] DREG_ISTAT = 7'h02;
	localparam logic [6:0] DREG_LIVE = 7'h03;
	localparam logic [7:0] CTRL_RST = 8'h21;
	localparam logic [7:0] IMASK_RST = 8'h00;
	localparam int CTRL_IRQ_EN = 0;
	localparam int CTRL_LOOP_LO = 1;
	localparam int CTRL_RXINV = 3;
	localparam int CTRL_TXINV = 4;
	localparam int CTRL_RECEIVER_ON = 5;
	localparam int CTRL_RECEIVER_MONITOR_MODE = 6;
	localparam int CTRL_MUTE = 7;
	localparam int EV_LOS_SET = 0;
	localparam int EV_LOS_CLR = 1;

	// ****************************************
	// loopback modes, remote bit first
	// ****************************************
	typedef enum logic [1:0] {
		LOOP_NORMAL = 2'b00,
		LOOP_ANALOG_LOCAL = 2'b01,
		LOOP_REMOTE = 2'b10,
		LOOP_DIGITAL = 2'b11
	} shc_loop_e;

	// ****************************************
	// device pin synchroniser layout
	// ****************************************
	localparam int PIN_RRST = 7;
	localparam int PIN_CS = 6;
	localparam int PIN_SCLK = 5;
	localparam int PIN_SDI = 4;
	localparam int PIN_LLB = 3;
	localparam int PIN_RLB = 2;
	localparam int PIN_SDO = 1;
	localparam int PIN_INT = 0;
	localparam logic [7:0] SYNC_RST = 8'hC1;

	// ****************************************
	// controller avalon registers (byte addresses)
	// ****************************************
	localparam logic [4:0] AV_CMD = 5'h00;
	localparam logic [4:0] AV_STAT = 5'h04;
	localparam logic [4:0] AV_CTRL = 5'h08;
	localparam logic [4:0] AV_IMASK = 5'h0C;
	localparam logic [4:0] AV_ISTAT = 5'h10;
	localparam int CMD_READ_BIT = 15;
	localparam int HEV_DONE = 0;
	localparam int HEV_DEVIRQ = 1;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCLK_PERIOD_NS = 800;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);
endpackage
`default_nettype wire

/* File: rtl/shc_link_if.sv */
`default_nettype none
interface shc_link_if;
	logic cs_n;
	logic sclk;
	logic serial_in;
	logic reg_reset_n;
	logic local_loop_select;
	logic remote_loop_select;
	logic serial_out_o;
	logic serial_out_oe;
	logic int_n_o;
	logic int_n_oe;
	logic serial_out;
	logic int_n;
	logic serial_out_ext;
	logic int_n_ext;

	// released pins show the board level: monitor input, pulled-up mute select
	assign serial_out = serial_out_oe ? serial_out_o : serial_out_ext;
	assign int_n = int_n_oe ? int_n_o : int_n_ext;

	modport dev (
		input cs_n, sclk, serial_in, reg_reset_n, local_loop_select, remote_loop_select,
		input serial_out, int_n,
		output serial_out_o, serial_out_oe, int_n_o, int_n_oe
	);
	modport host (
		output cs_n, sclk, serial_in, reg_reset_n, local_loop_select, remote_loop_select,
		input serial_out, int_n
	);
endinterface
`default_nettype wire

/* File: rtl/shc_device.sv */
// Operation
// - hardware mode: loop pins pick loopback mode
// - host mode ignores loop pins; held low
// - serial port active only while select low
// - serial input captured on clock rise
// - read data changes on clock fall
// - read shifts out addressed register contents
// - data out released after transfer, idle
// - hardware mode: port pins become controls
// - register reset low restores all defaults
// - host mode: interrupt drives pin low
// - enable bit zero suppresses interrupt pin
// - hardware mode: interrupt pin selects mute
// - mute forces rails low during loss
`default_nettype none
module shc_device
	import shc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic host_mode,
	input wire logic loss_of_signal,
	input wire logic rx_pos_in,
	input wire logic rx_neg_in,
	output logic [1:0] loopback_mode,
	output logic receive_clock_invert,
	output logic transmit_clock_invert,
	output logic receiver_on,
	output logic receiver_monitor_mode,
	output logic mute_on_signal_loss,
	output logic recovered_positive_rail,
	output logic recovered_negative_rail,
	shc_link_if.dev link
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [7:0] pins;
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic sclk_d_reg;

	assign pins = {link.reg_reset_n, link.cs_n, link.sclk, link.serial_in,
		link.local_loop_select, link.remote_loop_select, link.serial_out, link.int_n};

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
			sclk_d_reg <= 1'b0;
		end else if (ce) begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			sclk_d_reg <= sync2_reg[PIN_SCLK];
		end
	end

	logic sel;
	logic sclk_rise;
	logic sclk_fall;
	logic regs_default;

	assign sel = host_mode && !sync2_reg[PIN_CS];
	assign sclk_rise = sel && sync2_reg[PIN_SCLK] && !sclk_d_reg;
	assign sclk_fall = sel && !sync2_reg[PIN_SCLK] && sclk_d_reg;
	assign regs_default = !reset_n || !sync2_reg[PIN_RRST];

	// ****************************************
	// serial frame engine
	// ****************************************
	logic [4:0] bit_cnt_reg;
	logic [6:0] shift_in_reg;
	logic [6:0] addr_reg;
	logic read_reg;
	logic rd_active_reg;
	logic [7:0] out_shift_reg;
	logic sdo_reg;
	logic sdo_oe_reg;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_data;
	logic cmd_done;
	logic rd_cmd;
	logic wr_en;
	logic [7:0] rd_value;

	assign cmd_addr = {shift_in_reg[5:0], sync2_reg[PIN_SDI]};
	assign cmd_data = {shift_in_reg, sync2_reg[PIN_SDI]};
	assign cmd_done = sclk_rise && bit_cnt_reg == CNT_CMD_LAST;
	assign rd_cmd = cmd_done && shift_in_reg[6];
	assign wr_en = sclk_rise && bit_cnt_reg == CNT_FRAME_LAST && !read_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bit_cnt_reg <= 5'h00;
			shift_in_reg <= 7'h00;
			addr_reg <= 7'h00;
			read_reg <= 1'b0;
		end else if (ce) begin
			if (!sel) begin
				bit_cnt_reg <= 5'h00;
			end else if (sclk_rise && bit_cnt_reg != CNT_DONE) begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
				shift_in_reg <= cmd_data[6:0];
				if (cmd_done) begin
					read_reg <= shift_in_reg[6];
					addr_reg <= cmd_addr;
				end
			end
		end
	end

	// extra clocks after the frame are ignored until select rises
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_active_reg <= 1'b0;
			out_shift_reg <= 8'h00;
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else if (ce) begin
			if (!sel) begin
				rd_active_reg <= 1'b0;
				sdo_oe_reg <= 1'b0;
			end else if (rd_cmd) begin
				rd_active_reg <= 1'b1;
				out_shift_reg <= rd_value;
			end else if (sclk_rise && bit_cnt_reg == CNT_FRAME_LAST) begin
				rd_active_reg <= 1'b0;
				sdo_oe_reg <= 1'b0;
			end else if (sclk_fall && rd_active_reg) begin
				sdo_oe_reg <= 1'b1;
				sdo_reg <= out_shift_reg[7];
				out_shift_reg <= {out_shift_reg[6:0], 1'b0};
			end
		end
	end

	// ****************************************
	// command registers
	// ****************************************
	logic [7:0] ctrl_reg;
	logic [7:0] imask_reg;
	logic [1:0] istat_reg;
	logic los_d_reg;
	logic [1:0] events;
	logic istat_rd;

	assign events = {!loss_of_signal && los_d_reg, loss_of_signal && !los_d_reg};
	assign istat_rd = rd_cmd && cmd_addr == DREG_ISTAT;

	always_comb begin
		rd_value = 8'h00;
		unique case (cmd_addr)
			DREG_CTRL: rd_value = ctrl_reg;
			DREG_IMASK: rd_value = imask_reg;
			DREG_ISTAT: rd_value = {6'h00, istat_reg};
			DREG_LIVE: rd_value = {7'h00, loss_of_signal};
			default: rd_value = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (regs_default) begin
			ctrl_reg <= CTRL_RST;
			imask_reg <= IMASK_RST;
		end else if (ce && wr_en) begin
			if (addr_reg == DREG_CTRL) begin
				ctrl_reg <= cmd_data;
			end
			if (addr_reg == DREG_IMASK) begin
				imask_reg <= cmd_data;
			end
		end
	end

	// new events win over the read that clears them
	always_ff @(posedge clk) begin
		if (regs_default) begin
			istat_reg <= 2'b00;
			los_d_reg <= 1'b0;
		end else if (ce) begin
			los_d_reg <= loss_of_signal;
			istat_reg <= (istat_rd ? 2'b00 : istat_reg) | events;
		end
	end

	// ****************************************
	// interrupt pin and hardware mode
	// ****************************************
	logic irq_pending;
	logic int_o_reg;
	logic int_oe_reg;
	logic mute;

	assign irq_pending = ctrl_reg[CTRL_IRQ_EN] && |(istat_reg & imask_reg[1:0]);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			int_o_reg <= 1'b1;
			int_oe_reg <= 1'b0;
		end else if (ce) begin
			int_oe_reg <= host_mode;
			int_o_reg <= !irq_pending;
		end
	end

	assign link.serial_out_o = sdo_reg;
	assign link.serial_out_oe = sdo_oe_reg && host_mode;
	assign link.int_n_o = int_o_reg;
	assign link.int_n_oe = int_oe_reg;

	assign mute = host_mode ? ctrl_reg[CTRL_MUTE] : sync2_reg[PIN_INT];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			loopback_mode <= LOOP_NORMAL;
			receive_clock_invert <= 1'b0;
			transmit_clock_invert <= 1'b0;
			receiver_on <= 1'b0;
			receiver_monitor_mode <= 1'b0;
			mute_on_signal_loss <= 1'b0;
			recovered_positive_rail <= 1'b0;
			recovered_negative_rail <= 1'b0;
		end else if (ce) begin
			if (host_mode) begin
				loopback_mode <= ctrl_reg[CTRL_LOOP_LO +: 2];
				receive_clock_invert <= ctrl_reg[CTRL_RXINV];
				transmit_clock_invert <= ctrl_reg[CTRL_TXINV];
				receiver_on <= ctrl_reg[CTRL_RECEIVER_ON];
				receiver_monitor_mode <= ctrl_reg[CTRL_RECEIVER_MONITOR_MODE];
			end else begin
				loopback_mode <= {sync2_reg[PIN_RLB], sync2_reg[PIN_LLB]};
				receive_clock_invert <= sync2_reg[PIN_CS];
				transmit_clock_invert <= sync2_reg[PIN_SCLK];
				receiver_on <= sync2_reg[PIN_SDI];
				receiver_monitor_mode <= sync2_reg[PIN_SDO];
			end
			mute_on_signal_loss <= mute;
			recovered_positive_rail <= rx_pos_in && !(mute && loss_of_signal);
			recovered_negative_rail <= rx_neg_in && !(mute && loss_of_signal);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/shc_host.sv */
`default_nettype none
module shc_host
	import shc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	shc_link_if.host link
);
	// ****************************************
	// link input synchronisers
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW = 2'b01,
		ST_HIGH = 2'b10,
		ST_END = 2'b11
	} shc_state_e;

	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic int_d_reg;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1_reg <= 2'b10;
			sync2_reg <= 2'b10;
			int_d_reg <= 1'b1;
		end else if (ce) begin
			sync1_reg <= {link.int_n, link.serial_out};
			sync2_reg <= sync1_reg;
			int_d_reg <= sync2_reg[1];
		end
	end

	// ****************************************
	// avalon slave
	// ****************************************
	shc_state_e state_reg;
	logic busy;
	logic rd_done_reg;
	logic cmd_wr;
	logic acc_rd;
	logic [7:0] rdata_reg;
	logic [15:0] cmd_reg;
	logic [1:0] ctrl_reg;
	logic [1:0] imask_reg;
	logic [1:0] istat_reg;
	logic [1:0] events;
	logic [1:0] istat_clr;
	logic done_ev;

	assign busy = state_reg != ST_IDLE;
	assign avs_waitrequest = (avs_read && !rd_done_reg) ||
		(avs_write && avs_address == AV_CMD && busy);
	assign cmd_wr = avs_write && !avs_waitrequest && avs_address == AV_CMD && ce;
	assign acc_rd = avs_read && rd_done_reg;
	assign events = {!sync2_reg[1] && int_d_reg, done_ev};
	assign irq = |(istat_reg & imask_reg);
	// clear only what the read returned, so an event in its wait cycle survives
	assign istat_clr = (acc_rd && avs_address == AV_ISTAT) ? avs_readdata[1:0] : 2'b00;

	// reads answer one cycle late so read data leaves a flip-flop
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_done_reg <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else if (ce) begin
			rd_done_reg <= avs_read && !rd_done_reg;
			unique case (avs_address)
				AV_STAT: avs_readdata <= {16'h0000, rdata_reg, 5'h00, !sync2_reg[1], 1'b0, busy};
				AV_CTRL: avs_readdata <= {30'h0, ctrl_reg};
				AV_IMASK: avs_readdata <= {30'h0, imask_reg};
				AV_ISTAT: avs_readdata <= {30'h0, istat_reg};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_reg <= 2'b00;
			imask_reg <= 2'b00;
			istat_reg <= 2'b00;
		end else if (ce) begin
			if (avs_write && avs_address == AV_CTRL) begin
				ctrl_reg <= avs_writedata[1:0];
			end
			if (avs_write && avs_address == AV_IMASK) begin
				imask_reg <= avs_writedata[1:0];
			end
			istat_reg <= (istat_reg & ~istat_clr) | events;
		end
	end

	// ****************************************
	// serial master, clock made by divider
	// ****************************************
	logic [3:0] tmr_reg;
	logic [4:0] bit_reg;
	logic [15:0] rx_reg;
	logic half_end;

	assign half_end = tmr_reg == SCLK_HALF_LAST;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			tmr_reg <= 4'h0;
			bit_reg <= 5'h00;
			cmd_reg <= 16'h0000;
			rx_reg <= 16'h0000;
			rdata_reg <= 8'h00;
			done_ev <= 1'b0;
		end else if (ce) begin
			done_ev <= 1'b0;
			tmr_reg <= (busy && !half_end) ? tmr_reg + 4'h1 : 4'h0;
			unique case (state_reg)
				ST_IDLE: if (cmd_wr) begin
					cmd_reg <= avs_writedata[15:0];
					bit_reg <= 5'h00;
					state_reg <= ST_LOW;
				end
				ST_LOW: if (half_end) begin
					rx_reg <= {rx_reg[14:0], sync2_reg[0]};
					state_reg <= ST_HIGH;
				end
				ST_HIGH: if (half_end) begin
					if (bit_reg == CNT_FRAME_LAST) begin
						state_reg <= ST_END;
					end else begin
						bit_reg <= bit_reg + 5'h01;
						cmd_reg <= {cmd_reg[14:0], 1'b0};
						state_reg <= ST_LOW;
					end
				end
				ST_END: if (half_end) begin
					rdata_reg <= rx_reg[CMD_BITS-1:0];
					done_ev <= 1'b1;
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	assign link.cs_n = !(state_reg == ST_LOW || state_reg == ST_HIGH || state_reg == ST_END);
	assign link.sclk = state_reg == ST_HIGH;
	assign link.serial_in = cmd_reg[CMD_READ_BIT];
	assign link.reg_reset_n = !ctrl_reg[0];
	// host mode: loop pins held at ground
	assign link.local_loop_select = 1'b0;
	assign link.remote_loop_select = 1'b0;
endmodule
`default_nettype wire

/* File: testbench/shc_checker.sv */
`default_nettype none
module shc_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic local_loop_select,
	input wire logic remote_loop_select,
	input wire logic serial_out_o,
	input wire logic serial_out_oe,
	input wire logic int_n_o,
	input wire logic int_n_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sclk_d;
	logic [4:0] rises;
	// ****************
	// rises per frame
	// ****************
	always_ff @(posedge clk) begin
		sclk_d <= sclk;
	end
	// cleared while deselected, so an aborted frame cannot leak into the next
	always_ff @(posedge clk) begin
		if (!reset_n || cs_n) begin
			rises <= 5'h00;
		end else if (sclk && !sclk_d) begin
			rises <= rises + 5'h01;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	a_loop_pins_low: assert property (!local_loop_select && !remote_loop_select)
		else $error("loop select high");
	a_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("clock runs outside frame");
	a_select_lead: assert property ($fell(cs_n) |-> (!sclk && !cs_n) [*8])
		else $error("clock too soon after select");
	a_sdi_stable: assert property ($rose(sclk) |-> $stable(serial_in))
		else $error("data in moved at rise");
	a_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("clock high time wrong");
	a_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe)
		&& $changed(serial_out_o) |-> !sclk)
		else $error("data out moved while clock high");
	a_oe_after_cmd: assert property ($rose(serial_out_oe) |-> !cs_n && rises == 5'h08)
		else $error("data out enabled at wrong bit");
	a_oe_released: assert property (cs_n [*6] |-> !serial_out_oe)
		else $error("data out driven while idle");
	a_frame_bits: assert property ($rose(cs_n) |-> rises == 5'h10)
		else $error("frame length wrong");
	a_int_driven: assert property ($past(reset_n) |-> int_n_oe)
		else $error("interrupt pin not driven");
	c_read: cover property ($rose(serial_out_oe));
	c_frame: cover property ($rose(cs_n));
	c_int: cover property ($fell(int_n_o) && int_n_oe);
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`default_nettype none
module tb;
	import shc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ce = 1'b1;
	logic los = 1'b0;
	logic rx_p = 1'b1;
	logic rx_n = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [1:0] dev_loop;
	logic [3:0] dev_cfg;
	logic [1:0] hw_loop;
	logic hw_rxinv, hw_txinv, hw_receiver_on, hw_mon, hw_mute, hw_pos, hw_neg;
	logic [31:0] q;
	int n_mismatch = 0;
	int compares = 0;
	shc_link_if link();
	shc_link_if link_hw();
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	shc_host i_shc_host (.clk(clk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
	shc_device i_shc_device (.clk(clk), .reset_n(reset_n), .ce(ce), .host_mode(1'b1),
		.loss_of_signal(los), .rx_pos_in(rx_p), .rx_neg_in(rx_n), .loopback_mode(dev_loop),
		.receive_clock_invert(dev_cfg[3]), .transmit_clock_invert(dev_cfg[2]),
		.receiver_on(dev_cfg[1]), .receiver_monitor_mode(dev_cfg[0]), .mute_on_signal_loss(),
		.recovered_positive_rail(), .recovered_negative_rail(), .link(link));
	// hardware-mode end: bench plays the board, pins held as levels
	shc_device i_shc_device_hw (.clk(clk), .reset_n(reset_n), .ce(ce), .host_mode(1'b0),
		.loss_of_signal(los), .rx_pos_in(rx_p), .rx_neg_in(rx_n), .loopback_mode(hw_loop),
		.receive_clock_invert(hw_rxinv), .transmit_clock_invert(hw_txinv),
		.receiver_on(hw_receiver_on), .receiver_monitor_mode(hw_mon), .mute_on_signal_loss(hw_mute),
		.recovered_positive_rail(hw_pos), .recovered_negative_rail(hw_neg), .link(link_hw));
	shc_checker i_shc_checker (.clk(clk), .reset_n(reset_n), .cs_n(link.cs_n),
		.sclk(link.sclk), .serial_in(link.serial_in), .local_loop_select(link.local_loop_select),
		.remote_loop_select(link.remote_loop_select), .serial_out_o(link.serial_out_o),
		.serial_out_oe(link.serial_out_oe), .int_n_o(link.int_n_o), .int_n_oe(link.int_n_oe));
	// ****************
	// shared tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// waitrequest sampled just before the edge to avoid racing its update
	task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d);
		logic w;
		@(posedge clk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(negedge clk);
			w = avs_waitrequest;
			q = avs_readdata;
			@(posedge clk);
		end while (w !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d);
		av(1'b0, AV_CMD, {16'h0000, rd, a, d});
		do begin
			av(1'b1, AV_STAT, 32'h00000000);
		end while (q[0] !== 1'b0);
	endtask
	task automatic wait_clk;
		repeat (10) @(posedge clk);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_idle;
		check(32'(link.serial_out_oe), 32'h0, "data out driven");
		av(1'b1, 5'h14, 32'h0);
		check(q, 32'h0, "unmapped read");
		frame(1'b1, DREG_CTRL, 8'h00);
		check(32'(q[15:8]), 32'(CTRL_RST), "ctrl default");
		frame(1'b1, 7'h7F, 8'h00);
		check(32'(q[15:8]), 32'h0, "unused reg");
		check(32'(irq), 32'h0, "irq while masked");
	endtask
	task automatic t_wr_rd;
		frame(1'b0, DREG_CTRL, 8'h5A);
		frame(1'b1, DREG_CTRL, 8'h00);
		check(32'(q[15:8]), 32'h5A, "ctrl readback");
		check(32'(dev_loop), 32'h1, "loop from ctrl");
		check(32'(dev_cfg), 32'hD, "config from ctrl");
	endtask
	task automatic t_reg_reset;
		av(1'b0, AV_CTRL, 32'h1);
		wait_clk();
		check(32'(link.reg_reset_n), 32'h0, "reg reset pin");
		av(1'b0, AV_CTRL, 32'h0);
		wait_clk();
		frame(1'b1, DREG_CTRL, 8'h00);
		check(32'(q[15:8]), 32'(CTRL_RST), "ctrl not restored");
		check(32'(dev_loop), 32'h0, "loop not restored");
		check(32'(dev_cfg), 32'h2, "config not restored");
	endtask
	task automatic t_irq;
		frame(1'b0, DREG_IMASK, 8'h03);
		av(1'b0, AV_IMASK, 32'h2);
		av(1'b1, AV_ISTAT, 32'h0);
		los <= 1'b1;
		wait_clk();
		check(32'(link.int_n), 32'h0, "no interrupt");
		check(32'(irq), 32'h1, "host irq low");
		av(1'b1, AV_STAT, 32'h0);
		check(32'(q[2]), 32'h1, "pin status");
		av(1'b1, AV_ISTAT, 32'h0);
		check(32'(q[1]), 32'h1, "event missing");
		@(negedge clk);
		check(32'(irq), 32'h0, "irq not cleared");
		frame(1'b1, DREG_ISTAT, 8'h00);
		check(32'(q[15:8]), 32'h01, "loss rise event");
		wait_clk();
		check(32'(link.int_n), 32'h1, "interrupt stuck");
		frame(1'b0, DREG_CTRL, 8'h20);
		los <= 1'b0;
		wait_clk();
		check(32'(link.int_n), 32'h1, "disabled interrupt");
		frame(1'b0, DREG_CTRL, CTRL_RST);
		wait_clk();
		check(32'(link.int_n), 32'h0, "enabled interrupt");
		frame(1'b1, DREG_ISTAT, 8'h00);
		check(32'(q[15:8]), 32'h02, "loss fall event");
	endtask
	task automatic t_hw;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			link_hw.remote_loop_select <= m[1];
			link_hw.local_loop_select <= m[0];
			wait_clk();
			check(32'(hw_loop), 32'(m), "loop pins");
		end
		los <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			link_hw.cs_n <= v[0];
			link_hw.sclk <= !v[0];
			link_hw.serial_in <= v[0];
			link_hw.serial_out_ext <= v[0];
			link_hw.int_n_ext <= v[0];
			wait_clk();
			check(32'({hw_rxinv, hw_txinv, hw_receiver_on, hw_mon}),
				32'({v[0], !v[0], v[0], v[0]}), "pins");
			check(32'(hw_mute), 32'(v[0]), "mute select");
			check(32'({hw_pos, hw_neg}), v[0] ? 32'h0 : 32'h3, "rails mute");
		end
		check(32'({hw_pos, hw_neg}), 32'h0, "rails not muted");
		los <= 1'b0;
		wait_clk();
		check(32'({hw_pos, hw_neg}), 32'h3, "rails stuck");
		// enable low must freeze the pin path
		ce <= 1'b0;
		link_hw.remote_loop_select <= 1'b0;
		link_hw.local_loop_select <= 1'b0;
		wait_clk();
		check(32'(hw_loop), 32'h3, "frozen by enable");
		ce <= 1'b1;
		wait_clk();
		check(32'(hw_loop), 32'h0, "loop pins");
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		link_hw.cs_n = 1'b1;
		link_hw.sclk = 1'b0;
		link_hw.serial_in = 1'b0;
		link_hw.reg_reset_n = 1'b1;
		link_hw.local_loop_select = 1'b0;
		link_hw.remote_loop_select = 1'b0;
		link_hw.serial_out_ext = 1'b0;
		link_hw.int_n_ext = 1'b1;
		link.serial_out_ext = 1'b0;
		link.int_n_ext = 1'b1;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_idle();
		t_wr_rd();
		t_reg_reset();
		t_irq();
		t_hw();
		finish_test();
	end
	// about 10 frames of some 300 cycles each, with ample margin
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
endmodule
`default_nettype wire
